// [include/pll_lock_detect_vco_cal_control_defines.vh]
// Constants for the PLL lock detector, VCO calibration and sync control block.
// Assumes inclusion by bare name from design files of this block only.
`ifndef PLL_LOCK_DETECT_VCO_CAL_CONTROL_DEFINES_VH
`define PLL_LOCK_DETECT_VCO_CAL_CONTROL_DEFINES_VH

// Register indexes on the plain register port
`define PLL_REG_LOCK_CAL      10'h018
`define PLL_REG_SYNC_DELAY    10'h019
`define PLL_REG_UPDATE        10'h232
`define PLL_REG_STATUS        10'h300
`define PLL_REG_IRQ_STATUS    10'h301
`define PLL_REG_IRQ_CLEAR     10'h302
`define PLL_REG_IRQ_ENABLE    10'h303

// Reset values
`define PLL_RST_LOCK_CAL      8'h06
`define PLL_RST_SYNC_DELAY    8'h00
`define PLL_RST_IRQ_ENABLE    3'h0

// Field positions in the lock detect and VCO calibration register
`define PLL_FLD_LOCK_CNT_HI   6
`define PLL_FLD_LOCK_CNT_LO   5
`define PLL_FLD_WIN_LOW       4
`define PLL_FLD_DLD_DISABLE   3
`define PLL_FLD_CAL_DIV_HI    2
`define PLL_FLD_CAL_DIV_LO    1
`define PLL_FLD_CAL_NOW       0
// Field positions in the counter sync register and the update register
`define PLL_FLD_SYNC_MODE_HI  7
`define PLL_FLD_SYNC_MODE_LO  6
`define PLL_FLD_UPDATE        0

// Sync pin modes
`define PLL_SYNC_NONE_A       2'h0
`define PLL_SYNC_ASYNC        2'h1
`define PLL_SYNC_SYNC         2'h2
`define PLL_SYNC_NONE_B       2'h3

// Lock counts per selection
`define PLL_LOCK_CNT_0        8'h05
`define PLL_LOCK_CNT_1        8'h10
`define PLL_LOCK_CNT_2        8'h40
`define PLL_LOCK_CNT_3        8'hff

// Phase windows in core clock cycles
`define PLL_WIN_HIGH          8'h04
`define PLL_LOSS_HIGH         8'h08
`define PLL_WIN_LOW           8'h02
`define PLL_LOSS_LOW          8'h04
`define PLL_MEAS_MAX          8'hff

// Calibration divider half periods in reference edges, and calibration length in calibration clock ticks
`define PLL_CAL_HALF_2        4'h1
`define PLL_CAL_HALF_4        4'h2
`define PLL_CAL_HALF_8        4'h4
`define PLL_CAL_HALF_16       4'h8
`define PLL_CAL_TICKS         8'h08

// Status and interrupt bits
`define PLL_EV_LOCK_SET       0
`define PLL_EV_LOCK_LOST      1
`define PLL_EV_CAL_DONE       2

`endif

// [logic/pll_pin_sync.v]
// Two flip-flop synchroniser for one pin with a rising edge pulse.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pll_pin_sync #(
    parameter INIT = 1'b0
) (
    input  wire core_clk_i,
    input  wire rst_i,
    input  wire pin_i,
    output wire level_o,
    output wire rise_o
);
    reg meta;
    reg level;
    reg level_prev;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            meta       <= INIT;
            level      <= INIT;
            level_prev <= INIT;
        end else begin
            meta       <= pin_i;
            level      <= meta;
            level_prev <= level;
        end
    end

    assign level_o = level;
    assign rise_o  = level & ~level_prev;
endmodule // pll_pin_sync
`default_nettype wire

// [logic/pll_cal_divider.v]
// Calibration clock divider counting reference edges.
// Assumes ref_rise_i is a one-cycle pulse on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pll_lock_detect_vco_cal_control_defines.vh"
module pll_cal_divider (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire [1:0] ratio_sel_i,
    input  wire       ref_rise_i,
    output reg        cal_clk_o,
    output reg        cal_tick_o
);
    reg  [3:0] edge_cnt;
    reg  [3:0] half;

    always @* begin
        case (ratio_sel_i)
            2'h0:    half = `PLL_CAL_HALF_2;
            2'h1:    half = `PLL_CAL_HALF_4;
            2'h2:    half = `PLL_CAL_HALF_8;
            default: half = `PLL_CAL_HALF_16;
        endcase
    end

    // Ratio change applies to the half period in progress, from the next reference edge
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            edge_cnt   <= 4'h0;
            cal_clk_o  <= 1'b0;
            cal_tick_o <= 1'b0;
        end else begin
            cal_tick_o <= 1'b0;
            if (ref_rise_i) begin
                if (edge_cnt + 4'h1 >= half) begin
                    edge_cnt   <= 4'h0;
                    cal_clk_o  <= ~cal_clk_o;
                    cal_tick_o <= ~cal_clk_o;
                end else begin
                    edge_cnt <= edge_cnt + 4'h1;
                end
            end
        end
    end
endmodule // pll_cal_divider
`default_nettype wire

// [logic/pll_lock_detect_vco_cal_control.v]
// PLL lock detector, VCO calibration trigger and counter sync control.
// Assumes a register master on core_clk_i; ref, feedback and sync pins are asynchronous.
//
// Overview of operation
// - Lock count field picks 5, 16, 64 or 255 consecutive in-window cycles.
// - Only consecutive in-window detector cycles count; lock flag sets at selected count.
// - Lock flag sets when edge time difference is below the lock window.
// - Lock flag holds until difference exceeds the larger loss-of-lock threshold.
// - Disable bit 0 runs lock detection normally; 1 turns it off.
// - Calibration clock is reference divided by 2, 4, 8 or 16.
// - Calibration starts only on a rising trigger bit in the active copy.
// - Trigger returning to 0 discards the stored calibration result.
// - Sync mode field: 00/11 nothing, 01 asynchronous, 10 synchronous prescaler reset.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pll_lock_detect_vco_cal_control_defines.vh"
module pll_lock_detect_vco_cal_control (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire [9:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    input  wire       ref_clk_i,
    input  wire       fb_clk_i,
    input  wire       sync_n_i,
    output reg        lock_flag_o,
    output reg        cal_busy_o,
    output reg        cal_valid_o,
    output wire       cal_clk_o,
    output reg        prescaler_reset_o,
    output reg        irq_o
);
    reg  [7:0] stage_lock_cal;
    reg  [7:0] stage_sync;
    reg  [7:0] act_lock_cal;
    reg  [7:0] act_sync;
    reg  [2:0] irq_status;
    reg  [2:0] irq_enable;
    reg  [2:0] next_irq_status;
    reg  [2:0] events;
    reg        meas_active;
    reg        meas_first_ref;
    reg  [7:0] meas_cnt;
    reg        eval;
    reg  [7:0] diff;
    reg  [7:0] lock_run;
    reg        lock_prev;
    reg        cal_trig_prev;
    reg  [7:0] cal_ticks;
    reg        cal_done_ev;
    wire       ref_rise;
    wire       fb_rise;
    wire       sync_level;
    wire       cal_tick;
    wire [1:0] lock_sel;
    wire       win_low;
    wire       dld_disable;
    wire       cal_now;
    wire [1:0] sync_mode;
    wire [7:0] win;
    wire [7:0] loss;
    wire       upd;
    wire       wr_lock_cal;
    wire       wr_sync;
    wire       wr_irq_enable;
    wire       wr_irq_clear;
    wire       in_window;
    wire       past_loss;
    wire       lock_reached;
    wire       sync_req;
    reg  [2:0] next_irq_enable;

    function [7:0] lock_target;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    lock_target = `PLL_LOCK_CNT_0;
                2'h1:    lock_target = `PLL_LOCK_CNT_1;
                2'h2:    lock_target = `PLL_LOCK_CNT_2;
                default: lock_target = `PLL_LOCK_CNT_3;
            endcase
        end
    endfunction

    function is_wr;
        input [9:0] addr;
        input [9:0] target;
        input       wr;
        begin
            is_wr = wr && (addr == target);
        end
    endfunction

    pll_pin_sync #(.INIT(1'b0)) u_ref_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (ref_clk_i),
        .level_o    (),
        .rise_o     (ref_rise)
    );

    pll_pin_sync #(.INIT(1'b0)) u_fb_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (fb_clk_i),
        .level_o    (),
        .rise_o     (fb_rise)
    );

    // Idle high so that reset does not look like a sync request
    pll_pin_sync #(.INIT(1'b1)) u_sync_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (sync_n_i),
        .level_o    (sync_level),
        .rise_o     ()
    );

    pll_cal_divider u_cal_div (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .ratio_sel_i (act_lock_cal[`PLL_FLD_CAL_DIV_HI:`PLL_FLD_CAL_DIV_LO]),
        .ref_rise_i  (ref_rise),
        .cal_clk_o   (cal_clk_o),
        .cal_tick_o  (cal_tick)
    );

    assign lock_sel    = act_lock_cal[`PLL_FLD_LOCK_CNT_HI:`PLL_FLD_LOCK_CNT_LO];
    assign win_low     = act_lock_cal[`PLL_FLD_WIN_LOW];
    assign dld_disable = act_lock_cal[`PLL_FLD_DLD_DISABLE];
    assign cal_now     = act_lock_cal[`PLL_FLD_CAL_NOW];
    assign sync_mode   = act_sync[`PLL_FLD_SYNC_MODE_HI:`PLL_FLD_SYNC_MODE_LO];
    assign win         = win_low ? `PLL_WIN_LOW : `PLL_WIN_HIGH;
    assign loss        = win_low ? `PLL_LOSS_LOW : `PLL_LOSS_HIGH;
    assign upd         = is_wr(reg_addr_i, `PLL_REG_UPDATE, reg_wr_i)
                         && reg_wdata_i[`PLL_FLD_UPDATE];

    // One decode per register keeps the write paths and the interrupt clear consistent
    assign wr_lock_cal   = is_wr(reg_addr_i, `PLL_REG_LOCK_CAL, reg_wr_i);
    assign wr_sync       = is_wr(reg_addr_i, `PLL_REG_SYNC_DELAY, reg_wr_i);
    assign wr_irq_enable = is_wr(reg_addr_i, `PLL_REG_IRQ_ENABLE, reg_wr_i);
    assign wr_irq_clear  = is_wr(reg_addr_i, `PLL_REG_IRQ_CLEAR, reg_wr_i);
    assign in_window     = diff < win;
    assign past_loss     = diff > loss;
    assign lock_reached  = {1'b0, lock_run} + 9'h001 >= {1'b0, lock_target(lock_sel)};
    assign sync_req      = ~sync_level;

    // Staging copies take writes; the update bit commits them to the active copies
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            stage_lock_cal <= `PLL_RST_LOCK_CAL;
            stage_sync     <= `PLL_RST_SYNC_DELAY;
            act_lock_cal   <= `PLL_RST_LOCK_CAL;
            act_sync       <= `PLL_RST_SYNC_DELAY;
            irq_enable     <= `PLL_RST_IRQ_ENABLE;
        end else begin
            if (wr_lock_cal) begin
                stage_lock_cal <= reg_wdata_i;
            end
            if (wr_sync) begin
                stage_sync <= reg_wdata_i;
            end
            irq_enable <= next_irq_enable;
            if (upd) begin
                act_lock_cal <= stage_lock_cal;
                act_sync     <= stage_sync;
            end
        end
    end

    // Read data stand only in the cycle after the read strobe
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `PLL_REG_LOCK_CAL:   reg_rdata_o <= stage_lock_cal;
                `PLL_REG_SYNC_DELAY: reg_rdata_o <= stage_sync;
                `PLL_REG_STATUS:     reg_rdata_o <= {5'h00, cal_valid_o, cal_busy_o, lock_flag_o};
                `PLL_REG_IRQ_STATUS: reg_rdata_o <= {5'h00, irq_status};
                `PLL_REG_IRQ_ENABLE: reg_rdata_o <= {5'h00, irq_enable};
                // Write-only registers read as zero
                `PLL_REG_UPDATE:     reg_rdata_o <= 8'h00;
                `PLL_REG_IRQ_CLEAR:  reg_rdata_o <= 8'h00;
                default:             reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Phase meter: cycles from the first edge to the other input's edge
    // A missing second edge saturates, which reads as far outside the window
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            meas_active    <= 1'b0;
            meas_first_ref <= 1'b0;
            meas_cnt       <= 8'h00;
            eval           <= 1'b0;
            diff           <= 8'h00;
        end else begin
            eval <= 1'b0;
            if (!meas_active) begin
                if (ref_rise && fb_rise) begin
                    eval <= 1'b1;
                    diff <= 8'h00;
                end else if (ref_rise || fb_rise) begin
                    meas_active    <= 1'b1;
                    meas_first_ref <= ref_rise;
                    meas_cnt       <= 8'h01;
                end
            end else if ((meas_first_ref && fb_rise) || (!meas_first_ref && ref_rise)) begin
                eval        <= 1'b1;
                diff        <= meas_cnt;
                meas_active <= 1'b0;
            end else if (meas_cnt == `PLL_MEAS_MAX) begin
                eval        <= 1'b1;
                diff        <= meas_cnt;
                meas_active <= 1'b0;
            end else begin
                meas_cnt <= meas_cnt + 8'h01;
            end
        end
    end

    // Lock flag with hysteresis between the lock window and the loss threshold
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            lock_flag_o <= 1'b0;
            lock_run    <= 8'h00;
        end else if (dld_disable) begin
            lock_flag_o <= 1'b0;
            lock_run    <= 8'h00;
        end else if (eval) begin
            if (in_window) begin
                if (lock_run != 8'hff) begin
                    lock_run <= lock_run + 8'h01;
                end
                if (lock_reached) begin
                    lock_flag_o <= 1'b1;
                end
            end else begin
                lock_run <= 8'h00;
                if (past_loss) begin
                    lock_flag_o <= 1'b0;
                end
            end
        end
    end

    // Calibration runs a fixed number of calibration clock ticks
    // Ticks only come while the reference is present, so a dead reference stalls it
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cal_trig_prev <= 1'b0;
            cal_busy_o    <= 1'b0;
            cal_valid_o   <= 1'b0;
            cal_ticks     <= 8'h00;
            cal_done_ev   <= 1'b0;
        end else begin
            cal_trig_prev <= cal_now;
            cal_done_ev   <= 1'b0;
            if (!cal_now) begin
                cal_busy_o  <= 1'b0;
                cal_valid_o <= 1'b0;
            end else if (!cal_trig_prev) begin
                cal_busy_o  <= 1'b1;
                cal_valid_o <= 1'b0;
                cal_ticks   <= 8'h00;
            end else if (cal_busy_o && cal_tick) begin
                if (cal_ticks == `PLL_CAL_TICKS - 8'h01) begin
                    cal_busy_o  <= 1'b0;
                    cal_valid_o <= 1'b1;
                    cal_done_ev <= 1'b1;
                end else begin
                    cal_ticks <= cal_ticks + 8'h01;
                end
            end
        end
    end

    // Asynchronous mode follows the pin at once; synchronous mode waits for a reference edge
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            prescaler_reset_o <= 1'b0;
        end else begin
            case (sync_mode)
                `PLL_SYNC_ASYNC: prescaler_reset_o <= sync_req;
                `PLL_SYNC_SYNC: begin
                    if (ref_rise) begin
                        prescaler_reset_o <= sync_req;
                    end
                end
                default: prescaler_reset_o <= 1'b0;
            endcase
        end
    end

    // Events are single-cycle pulses taken from registered levels
    always @* begin
        events                    = 3'h0;
        events[`PLL_EV_LOCK_SET]  = lock_flag_o & ~lock_prev;
        events[`PLL_EV_LOCK_LOST] = ~lock_flag_o & lock_prev;
        events[`PLL_EV_CAL_DONE]  = cal_done_ev;
    end

    // Enable writes reach irq_o together with the enable register, never a cycle late
    always @* begin
        next_irq_enable = irq_enable;
        if (wr_irq_enable) begin
            next_irq_enable = reg_wdata_i[2:0];
        end
    end

    // Set wins over a clear in the same cycle
    always @* begin
        next_irq_status = irq_status;
        if (wr_irq_clear) begin
            next_irq_status = irq_status & ~reg_wdata_i[2:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            lock_prev  <= 1'b0;
            irq_status <= 3'h0;
            irq_o      <= 1'b0;
        end else begin
            lock_prev  <= lock_flag_o;
            irq_status <= next_irq_status;
            irq_o      <= |(next_irq_status & next_irq_enable);
        end
    end
endmodule // pll_lock_detect_vco_cal_control
`default_nettype wire

// [verif/pll_lock_detect_vco_cal_control_asserts.sv]
// Checker for the lock, calibration, sync and register port behaviour.
// Assumes a bind to the top module; it shadows the staged and active copies itself.
`timescale 1ns/1ps
`default_nettype none
module pll_ctl_asserts (
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       sync_n_i,
    input wire logic       lock_flag_o,
    input wire logic       cal_busy_o,
    input wire logic       cal_valid_o,
    input wire logic       prescaler_reset_o,
    input wire logic       irq_o
);
    logic [7:0] stg_a, stg_b, act_a, act_b;
    logic [2:0] irq_en;

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Mirrors the update strobe so the checks see the same active copy as the logic
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stg_a  <= 8'h06;
            stg_b  <= 8'h00;
            act_a  <= 8'h06;
            act_b  <= 8'h00;
            irq_en <= 3'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 10'h018) begin
                stg_a <= reg_wdata_i;
            end
            if (reg_addr_i == 10'h019) begin
                stg_b <= reg_wdata_i;
            end
            if (reg_addr_i == 10'h303) begin
                irq_en <= reg_wdata_i[2:0];
            end
            if (reg_addr_i == 10'h232 && reg_wdata_i[0]) begin
                act_a <= stg_a;
                act_b <= stg_b;
            end
        end
    end

    sequence cal_armed;
        $rose(act_a[0]);
    endsequence
    sequence cal_dropped;
        $fell(act_a[0]);
    endsequence

    rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read slot");
    reset_quiet_a: assert property (disable iff (1'b0)
        $past(rst_i) |-> !lock_flag_o && !cal_busy_o && !cal_valid_o && !irq_o)
        else $error("output active after reset");
    busy_valid_excl_a: assert property (!(cal_busy_o && cal_valid_o))
        else $error("busy and valid together");
    cal_start_a: assert property (cal_armed |-> ##[0:2] cal_busy_o)
        else $error("calibration did not start");
    cal_rise_only_a: assert property ($rose(cal_busy_o) |-> act_a[0])
        else $error("calibration started without active trigger");
    cal_discard_a: assert property (cal_dropped |-> ##[0:2] (!cal_busy_o && !cal_valid_o))
        else $error("calibration result kept after trigger cleared");
    cal_done_valid_a: assert property ($fell(cal_busy_o) && act_a[0] |-> cal_valid_o)
        else $error("calibration ended without result");
    lock_off_a: assert property (act_a[3] [*3] |-> !lock_flag_o)
        else $error("lock flag while detector disabled");
    lock_needs_on_a: assert property ($rose(lock_flag_o) |-> !act_a[3])
        else $error("lock set while disabled");
    sync_idle_a: assert property ((act_b[7:6] == 2'h0 || act_b[7:6] == 2'h3) [*2]
        |-> !prescaler_reset_o)
        else $error("prescaler reset in idle sync mode");
    sync_async_a: assert property ((act_b[7:6] == 2'h1 && !sync_n_i) [*5]
        |-> prescaler_reset_o)
        else $error("prescaler reset missing in async mode");
    irq_masked_a: assert property ((irq_en == 3'h0) [*2] |-> !irq_o)
        else $error("interrupt with all enables clear");
endmodule // pll_ctl_asserts
`default_nettype wire

// [verif/pll_lock_detect_vco_cal_control_test.sv]
// Self-checking bench for the PLL lock, calibration and sync control block.
// Assumes the design files are compiled first; drives ref and feedback edges itself.
`timescale 1ns/1ps
`default_nettype none
module pll_lock_detect_vco_cal_control_test;
    logic       core_clk_i, rst_i, reg_wr_i, reg_rd_i, ref_clk_i, fb_clk_i, sync_n_i;
    logic [9:0] reg_addr_i;
    logic [7:0] reg_wdata_i, v;
    wire  [7:0] reg_rdata_o;
    wire        lock_flag_o, cal_busy_o, cal_valid_o, cal_clk_o, prescaler_reset_o, irq_o;
    int         n_errors, n_checks, n, n0, win, ratio, mdl_st;
    int         n_cal = 0;
    int         mdl_run = 0, mdl_lock = 0, mdl_on = 0, mdl_sel = 0;
    int         lock_tab[4] = '{5, 16, 64, 255};

    pll_lock_detect_vco_cal_control dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ref_clk_i, .fb_clk_i, .sync_n_i, .lock_flag_o,
        .cal_busy_o, .cal_valid_o, .cal_clk_o, .prescaler_reset_o, .irq_o);

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge cal_clk_o) n_cal++;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    // Every driver ends at a falling edge, so checks after it see settled outputs
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk(reg_rdata_o, e);
    endtask

    // One detector cycle: feedback rises d core cycles after the reference
    task automatic pulse(input int d);
        @(posedge core_clk_i);
        ref_clk_i <= 1'b1;
        repeat (d) @(posedge core_clk_i);
        fb_clk_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        ref_clk_i <= 1'b0;
        fb_clk_i  <= 1'b0;
        repeat (6 + $urandom % 4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        // Model of the run count and the hysteretic flag; loss threshold is twice the window
        if (mdl_on != 0) begin
            mdl_run = (d < win) ? mdl_run + 1 : 0;
            if (d < win && mdl_run >= lock_tab[mdl_sel]) begin
                mdl_lock = 1;
            end
            if (d > 2 * win) begin
                mdl_lock = 0;
            end
        end
        chk(8'(lock_flag_o), 8'(mdl_lock));
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        rst_i       = 1'b1;
        reg_addr_i  = 10'h000;
        reg_wdata_i = 8'h00;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        ref_clk_i   = 1'b0;
        fb_clk_i    = 1'b0;
        sync_n_i    = 1'b1;
        n_errors    = 0;
        n_checks    = 0;
        mdl_st      = 0;
        void'($urandom(24));
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_chk(10'h018, 8'h06);
        rd_chk(10'h019, 8'h00);
        rd_chk(10'h303, 8'h00);
        rd_chk(10'h301, 8'h00);
        wr(10'h300, 8'hff);
        rd_chk(10'h300, 8'h00);
        wr(10'h3ff, 8'h5a);
        rd_chk(10'h3ff, 8'h00);
        wr(10'h303, 8'hff);
        rd_chk(10'h303, 8'h07);
        wr(10'h018, 8'h5f);
        rd_chk(10'h018, 8'h5f);
        rd_chk(10'h232, 8'h00);
        wr(10'h303, 8'h03);
        $display("register test done");
        for (int s = 0; s < 4; s++) begin
            win = s[0] ? 2 : 4;
            wr(10'h018, 8'h08);
            wr(10'h232, 8'h01);
            wr(10'h018, {1'b0, s[1:0], s[0], 4'h0});
            wr(10'h232, 8'h01);
            mdl_sel  = s;
            mdl_run  = 0;
            mdl_lock = 0;
            mdl_on   = 1;
            repeat (lock_tab[s] - 1) pulse(win - 1);
            pulse(win);
            repeat (lock_tab[s] - 1) pulse($urandom % win);
            chk(8'(lock_flag_o), 8'h00);
            pulse(0);
            chk(8'(lock_flag_o), 8'h01);
            mdl_st |= 1;
            pulse(2 * win);
            chk(8'(lock_flag_o), 8'h01);
            pulse(2 * win + 1);
            chk(8'(lock_flag_o), 8'h00);
            mdl_st |= 2;
        end
        wr(10'h018, 8'h08);
        wr(10'h232, 8'h01);
        mdl_on = 0;
        repeat (6) pulse(0);
        chk(8'(lock_flag_o), 8'h00);
        chk(8'(irq_o), 8'h01);
        rd_chk(10'h301, 8'(mdl_st));
        wr(10'h303, 8'h00);
        chk(8'(irq_o), 8'h00);
        wr(10'h302, 8'h03);
        rd_chk(10'h301, 8'h00);
        wr(10'h303, 8'h07);
        $display("lock test done");
        // Detector held off so calibration alone drives the status bits
        for (int c = 0; c < 4; c++) begin
            ratio = 2 << c;
            wr(10'h018, {5'h01, c[1:0], 1'b0});
            wr(10'h232, 8'h01);
            wr(10'h018, {5'h01, c[1:0], 1'b1});
            tick(3);
            chk(8'(cal_busy_o), 8'h00);
            wr(10'h232, 8'h01);
            tick(2);
            chk(8'(cal_busy_o), 8'h01);
            n = 0;
            while (cal_busy_o === 1'b1 && n < 300) begin
                pulse(0);
                n++;
            end
            chk(8'(n > 7 * ratio && n <= 8 * ratio), 8'h01);
            chk(8'(cal_valid_o), 8'h01);
            n0 = n_cal;
            repeat (4 * ratio) pulse(0);
            chk(8'(n_cal - n0), 8'h04);
            wr(10'h232, 8'h01);
            tick(2);
            chk(8'(cal_busy_o), 8'h00);
            wr(10'h018, {5'h01, c[1:0], 1'b0});
            wr(10'h232, 8'h01);
            tick(2);
            chk(8'(cal_valid_o), 8'h00);
        end
        rd_chk(10'h301, 8'h04);
        chk(8'(irq_o), 8'h01);
        $display("calibration test done");
        for (int m = 0; m < 4; m++) begin
            v = 8'($urandom);
            v[7:6] = m[1:0];
            wr(10'h019, v);
            wr(10'h232, 8'h01);
            rd_chk(10'h019, v);
            @(posedge core_clk_i);
            sync_n_i <= 1'b0;
            tick(3);
            pulse(0);
            chk(8'(prescaler_reset_o), 8'(m == 1 || m == 2));
            @(posedge core_clk_i);
            sync_n_i <= 1'b1;
            tick(3);
            pulse(0);
            chk(8'(prescaler_reset_o), 8'h00);
        end
        $display("sync test done");
        tally_and_finish;
    end
endmodule // pll_lock_detect_vco_cal_control_test

bind pll_lock_detect_vco_cal_control pll_ctl_asserts chk_i (.core_clk_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sync_n_i, .lock_flag_o, .cal_busy_o,
    .cal_valid_o, .prescaler_reset_o, .irq_o);
`default_nettype wire
